// >>> inc/stack_ext_pkg.sv
package stack_ext_pkg;

    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 8;
    localparam int          PC_W        = 21;
    localparam int          OFFS_W      = 7;
    localparam int          LIT_W       = 6;
    localparam int          PTR_COUNT   = 3;

    // Quarter phases of one instruction cycle; Q1 edge takes the fetched word.
    localparam logic [1:0]  Q_DECODE    = 2'h0;
    localparam logic [1:0]  Q_ISSUE     = 2'h2;
    localparam logic [1:0]  Q_LAST      = 2'h3;

    localparam logic [7:0]  OP_INDEXED  = 8'hEB;
    localparam logic [7:0]  OP_SUBPTR   = 8'hE9;
    localparam logic [7:0]  OP_PUSH     = 8'hFA;
    localparam logic [3:0]  OP_SECOND   = 4'hF;
    localparam logic [1:0]  SEL_RETURN  = 2'h3;
    localparam logic [1:0]  SEL_FRAME   = 2'h2;

    // Indirect addressing registers: three windows of five bytes in the top page.
    localparam logic [3:0]  IND_PAGE    = 4'hF;
    localparam logic [7:0]  IND_BASE0   = 8'hEB;
    localparam logic [7:0]  IND_BASE1   = 8'hE3;
    localparam logic [7:0]  IND_BASE2   = 8'hDB;
    localparam logic [7:0]  IND_SPAN    = 8'h05;

    localparam logic [ADDR_W-1:0] PTR_RESET  = 12'h000;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
    localparam logic [ADDR_W-1:0] PTR_STEP   = 12'h001;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
    } rd_req_type;

    typedef struct packed {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_req_type;

    typedef enum logic [1:0] {
        ST_FIRST,
        ST_MOVE_FILE,
        ST_MOVE_INDEXED,
        ST_RET_NOP
    } dec_state_type;

endpackage

// >>> hw/index_adder.sv
`timescale 1ns/1ps
`default_nettype none

module index_adder
    import stack_ext_pkg::*;
(
    input  wire logic [ADDR_W-1:0] base,      // Stack frame pointer value
    input  wire logic [OFFS_W-1:0] offset,    // Literal offset from the word
    output logic      [ADDR_W-1:0] addr,      // Effective address, wraps in 4 KB
    output logic                   indirect   // Address hits an indirect register
);

    logic [7:0] low;

    assign addr = base + {{(ADDR_W-OFFS_W){1'b0}}, offset};
    assign low  = addr[7:0];

    // Unsigned compare trick: low - base < span means base <= low < base + span.
    always_comb begin
        indirect = (addr[11:8] == IND_PAGE) &&
                   ((8'(low - IND_BASE0) < IND_SPAN) ||
                    (8'(low - IND_BASE1) < IND_SPAN) ||
                    (8'(low - IND_BASE2) < IND_SPAN));
    end

endmodule

`default_nettype wire

// >>> hw/stack_frame_ext_instructions.sv
// Contract
// - Extensions decode only when the extended set enable is high.
// - Indexed-to-file source is frame pointer plus 7-bit first-word offset.
// - Indexed-to-file destination is the 12-bit literal of the second word.
// - Both indexed addresses may reach anywhere from 000h to FFFh.
// - A source in an indirect register moves the value 00h.
// - Indexed-to-indexed addresses are frame pointer plus separate 7-bit offsets.
// - Indexed-to-indexed with indirect destination writes nothing, acting as no-op.
// - Indexed-to-indexed decodes first word bit7 set, second word starting 1111.
// - Push literal stores the 8-bit immediate at the frame pointer address.
// - Push literal then decrements the frame pointer, in one cycle.
// - Subtract 6-bit literal from the pointer picked by the selector.
// - Subtract-from-pointer opcode is 1110 1001, selector, literal; one cycle.
// - Selector 11 runs subtract-and-return on the frame pointer only.
// - Subtract-and-return subtracts from frame pointer then loads PC from stack top.
// - Subtract-and-return takes two cycles, the second a no-op.
`timescale 1ns/1ps
`default_nettype none

module stack_frame_ext_instructions
    import stack_ext_pkg::*;
(
    input  wire logic              clk,                  // Core clock
    input  wire logic              nrst,                 // Asynchronous reset, low
    input  wire logic              extended_set_enable,  // Configuration setting
    input  wire logic              word_valid,           // Fetched word present at Q1
    input  wire logic [15:0]       fetch_word,           // Fetched instruction word
    input  wire logic [DATA_W-1:0] mem_rd_data,          // Read data, sampled at Q4
    input  wire logic [PC_W-1:0]   return_stack_top,     // Top of return stack
    input  wire logic              ptr_wr_en,            // Core loads a pointer
    input  wire logic [1:0]        ptr_wr_sel,           // Pointer the core loads
    input  wire logic [ADDR_W-1:0] ptr_wr_value,         // Value the core loads
    output logic      [1:0]        q_phase,              // Current quarter phase
    output logic                   claimed,              // Block owns this cycle
    output rd_req_type             mem_rd,               // Data memory read request
    output wr_req_type             mem_wr,               // Data memory write request
    output logic                   pc_load,              // Load PC, one clock in Q4
    output logic      [PC_W-1:0]   pc_value,             // Value for the PC
    output logic      [ADDR_W-1:0] file_pointers [PTR_COUNT] // Pointers 0..2
);

    dec_state_type     state;
    logic              at_decode;
    logic              is_ext;
    logic              dec_index;
    logic              dec_move_indexed_to_file;
    logic              dec_movss;
    logic              dec_push;
    logic              dec_sub;
    logic              dec_subret;
    logic              second_ok;
    logic              next_claimed;
    logic [ADDR_W-1:0] idx_addr;
    logic              idx_indirect;
    logic              src_indirect;
    logic [DATA_W-1:0] move_data;
    logic              wr_pending;
    logic              sub_pending;
    logic              push_pending;
    logic              ret_pending;
    logic [1:0]        sub_sel;
    logic [LIT_W-1:0]  sub_lit;

    assign at_decode = (q_phase == Q_DECODE);

    assign is_ext = extended_set_enable && word_valid && at_decode && (state == ST_FIRST);

    always_comb begin
        dec_index  = is_ext && (fetch_word[15:8] == OP_INDEXED);
        dec_move_indexed_to_file  = dec_index && !fetch_word[7];
        dec_movss  = dec_index && fetch_word[7];
        dec_push   = is_ext && (fetch_word[15:8] == OP_PUSH);
        dec_sub    = is_ext && (fetch_word[15:8] == OP_SUBPTR) &&
                     (fetch_word[7:6] != SEL_RETURN);
        dec_subret = is_ext && (fetch_word[15:8] == OP_SUBPTR) &&
                     (fetch_word[7:6] == SEL_RETURN);
        second_ok  = word_valid && at_decode && (fetch_word[15:12] == OP_SECOND) &&
                     ((state == ST_MOVE_FILE) || (state == ST_MOVE_INDEXED));
        next_claimed = dec_index || dec_push || dec_sub || dec_subret ||
                       (state != ST_FIRST);
    end

    index_adder u_index (
        .base     (file_pointers[SEL_FRAME]),
        .offset   (fetch_word[OFFS_W-1:0]),
        .addr     (idx_addr),
        .indirect (idx_indirect)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_phase <= 2'h0;
        end else begin
            q_phase <= q_phase + 2'h1;
        end
    end

    // A second word that is not 1111 drops the move, so a bad fetch cannot write.
    // Two-word move and subtract-and-return sequencing
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_FIRST;
        end else if (at_decode) begin
            case (state)
                ST_FIRST: begin
                    if (dec_move_indexed_to_file) begin
                        state <= ST_MOVE_FILE;
                    end else if (dec_movss) begin
                        state <= ST_MOVE_INDEXED;
                    end else if (dec_subret) begin
                        state <= ST_RET_NOP;
                    end
                end
                ST_MOVE_FILE, ST_MOVE_INDEXED: begin
                    if (word_valid) begin
                        state <= ST_FIRST;
                    end
                end
                ST_RET_NOP: begin
                    state <= ST_FIRST;
                end
                default: begin
                    state <= ST_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            claimed <= 1'b0;
        end else if (at_decode) begin
            claimed <= next_claimed;
        end
    end

    // Source address and read in first cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_rd       <= '0;
            src_indirect <= 1'b0;
            move_data    <= DATA_ZERO;
        end else if (dec_index) begin
            mem_rd.en    <= 1'b1;
            mem_rd.addr  <= idx_addr;
            src_indirect <= idx_indirect;
        end else if (q_phase == Q_LAST && mem_rd.en) begin
            mem_rd.en <= 1'b0;
            move_data <= src_indirect ? DATA_ZERO : mem_rd_data;
        end
    end

    // Address and data settle at Q1; the strobe only rises in Q4.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_wr     <= '0;
            wr_pending <= 1'b0;
        end else if (dec_push) begin
            mem_wr.addr <= file_pointers[SEL_FRAME];
            mem_wr.data <= fetch_word[7:0];
            wr_pending  <= 1'b1;
        end else if (second_ok && state == ST_MOVE_FILE) begin
            mem_wr.addr <= fetch_word[ADDR_W-1:0];
            mem_wr.data <= move_data;
            wr_pending  <= 1'b1;
        end else if (second_ok && state == ST_MOVE_INDEXED) begin
            mem_wr.addr <= idx_addr;
            mem_wr.data <= move_data;
            wr_pending  <= !idx_indirect;
        end else if (q_phase == Q_ISSUE) begin
            mem_wr.en <= wr_pending;
        end else if (q_phase == Q_LAST) begin
            mem_wr.en  <= 1'b0;
            wr_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sub_pending  <= 1'b0;
            push_pending <= 1'b0;
            ret_pending  <= 1'b0;
            sub_sel      <= 2'h0;
            sub_lit      <= '0;
        end else if (at_decode) begin
            sub_pending  <= dec_sub || dec_subret;
            push_pending <= dec_push;
            ret_pending  <= dec_subret;
            sub_sel      <= dec_subret ? SEL_FRAME : fetch_word[7:6];
            sub_lit      <= fetch_word[LIT_W-1:0];
        end else if (q_phase == Q_LAST) begin
            sub_pending  <= 1'b0;
            push_pending <= 1'b0;
            ret_pending  <= 1'b0;
        end
    end

    // Return loads PC from stack top
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_load  <= 1'b0;
            pc_value <= '0;
        end else if (q_phase == Q_ISSUE) begin
            pc_load  <= ret_pending;
            pc_value <= return_stack_top;
        end else begin
            pc_load  <= 1'b0;
        end
    end

    // The core's own load wins; it never overlaps a claimed cycle in practice.
    // Only the core's load, push and subtract touch pointers
    for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                file_pointers[i] <= PTR_RESET;
            end else if (ptr_wr_en && ptr_wr_sel == 2'(i)) begin
                file_pointers[i] <= ptr_wr_value;
            end else if (q_phase == Q_LAST && sub_pending && sub_sel == 2'(i)) begin
                file_pointers[i] <= file_pointers[i] - {{(ADDR_W-LIT_W){1'b0}}, sub_lit};
            end else if (q_phase == Q_LAST && push_pending && i == SEL_FRAME) begin
                file_pointers[i] <= file_pointers[i] - PTR_STEP;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_disabled_no_claim: assert property (
        (!extended_set_enable && state == ST_FIRST && at_decode) |=> !claimed)
        else $error("extension claimed while disabled");
    chk_source_sum: assert property (
        dec_index |=> mem_rd.en && mem_rd.addr ==
            12'($past(file_pointers[SEL_FRAME]) + {5'h00, $past(fetch_word[6:0])}))
        else $error("indexed source address wrong");
    chk_file_dest: assert property (
        (second_ok && state == ST_MOVE_FILE) |=> ##2 mem_wr.en &&
            mem_wr.addr == $past(fetch_word[11:0], 3))
        else $error("file destination wrong");
    chk_indirect_zero: assert property (
        (q_phase == Q_LAST && mem_rd.en && src_indirect) |=> move_data == DATA_ZERO)
        else $error("indirect source not zero");
    chk_indirect_dest_nop: assert property (
        (second_ok && state == ST_MOVE_INDEXED && idx_indirect) |=> !mem_wr.en [*4])
        else $error("write to indirect destination");
    chk_push_store: assert property (
        dec_push |=> ##2 mem_wr.en && mem_wr.data == $past(fetch_word[7:0], 3) &&
            mem_wr.addr == $past(file_pointers[SEL_FRAME], 3))
        else $error("push store wrong");
    chk_push_decrement: assert property (
        ((dec_push && !ptr_wr_en) ##1 !ptr_wr_en [*3]) |=>
            file_pointers[SEL_FRAME] == 12'($past(file_pointers[SEL_FRAME], 4) - 12'h001))
        else $error("push did not decrement");
    chk_subtract_value: assert property (
        ((dec_sub && !ptr_wr_en) ##1 !ptr_wr_en [*3]) |=> file_pointers[sub_sel] ==
            12'($past(file_pointers[fetch_word[7:6]], 4) - {6'h00, $past(fetch_word[5:0], 4)}))
        else $error("pointer subtract wrong");
    chk_return_load: assert property (
        dec_subret |=> ##2 pc_load && pc_value == $past(return_stack_top))
        else $error("return load wrong");
    chk_return_nop_cycle: assert property (
        dec_subret |-> ##5 (claimed && !pc_load && !mem_wr.en && !mem_rd.en) [*4])
        else $error("return second cycle not idle");
    chk_move_keeps_frame: assert property (
        ((dec_index && !ptr_wr_en) ##1 !ptr_wr_en [*7]) |=>
            file_pointers[SEL_FRAME] == $past(file_pointers[SEL_FRAME], 8))
        else $error("indexed move changed frame pointer");

    cov_move_file: cover property (second_ok && state == ST_MOVE_FILE);
    cov_move_indexed: cover property (second_ok && state == ST_MOVE_INDEXED);
    cov_push: cover property (dec_push);
    cov_sub_return: cover property (pc_load);

endmodule

`default_nettype wire

// >>> sim/stack_frame_ext_instructions_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module stack_frame_ext_instructions_tb
    import stack_ext_pkg::*;
;
    typedef struct packed {
        logic [15:0]       w1;
        logic [15:0]       w2;
        logic              two;
        logic [ADDR_W-1:0] frame;
        logic [3:0]        nwr;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        npc;
        logic [3:0]        clm;
        logic [ADDR_W-1:0] e0;
        logic [ADDR_W-1:0] e1;
        logic [ADDR_W-1:0] e2;
    } row_type;

    localparam logic [PC_W-1:0] TOS_VALUE = 21'h1ABCDE;

    logic              clk                 = 1'b0;
    logic              nrst                = 1'b0;
    logic              extended_set_enable = 1'b1;
    logic              word_valid          = 1'b0;
    logic [15:0]       fetch_word          = 16'h0000;
    logic [DATA_W-1:0] mem_rd_data         = 8'h00;
    logic [PC_W-1:0]   return_stack_top    = TOS_VALUE;
    logic              ptr_wr_en           = 1'b0;
    logic [1:0]        ptr_wr_sel          = 2'h0;
    logic [ADDR_W-1:0] ptr_wr_value        = 12'h000;
    logic [1:0]        q_phase;
    logic              claimed;
    rd_req_type        mem_rd;
    wr_req_type        mem_wr;
    logic              pc_load;
    logic [PC_W-1:0]   pc_value;
    logic [ADDR_W-1:0] fp [PTR_COUNT];
    logic [3:0]        n_wr, n_pc, n_clm;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [PC_W-1:0]   pc_seen;
    int                n_errors = 0;
    int                n_tests  = 0;
    int                cycles   = 0;
    localparam int     N_ROWS   = 12;
    row_type           rows [N_ROWS];
    int                n_rows   = 0;

    stack_frame_ext_instructions stack_frame_ext_instructions_i (
        .clk(clk), .nrst(nrst), .extended_set_enable(extended_set_enable),
        .word_valid(word_valid), .fetch_word(fetch_word), .mem_rd_data(mem_rd_data),
        .return_stack_top(return_stack_top), .ptr_wr_en(ptr_wr_en), .ptr_wr_sel(ptr_wr_sel),
        .ptr_wr_value(ptr_wr_value), .q_phase(q_phase), .claimed(claimed), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .pc_load(pc_load), .pc_value(pc_value), .file_pointers(fp)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end

    // Memory contents depend on the address, so a wrong source address shows in the data.
    function automatic logic [7:0] mfun(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction

    always @(posedge clk) begin
        mem_rd_data <= mfun(mem_rd.addr);
        if (mem_wr.en === 1'b1) begin
            n_wr    = n_wr + 4'h1;
            wr_addr = mem_wr.addr;
            wr_data = mem_wr.data;
        end
        if (pc_load === 1'b1) begin
            n_pc    = n_pc + 4'h1;
            pc_seen = pc_value;
        end
        if (claimed === 1'b1) n_clm = n_clm + 4'h1;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    function automatic void add_row(input logic [15:0] w1, input logic [15:0] w2,
            input logic two, input logic [11:0] fr, input logic [3:0] nwr,
            input logic [11:0] wa, input logic [7:0] wd, input logic [3:0] npc,
            input logic [3:0] clm, input logic [11:0] e0, input logic [11:0] e1,
            input logic [11:0] e2);
        rows[n_rows] = {w1, w2, two, fr, nwr, wa, wd, npc, clm, e0, e1, e2};
        n_rows++;
    endfunction

    task automatic load_ptrs(input logic [11:0] p0, input logic [11:0] p1, input logic [11:0] p2);
        @(posedge clk);
        ptr_wr_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            ptr_wr_sel   <= 2'(i);
            ptr_wr_value <= (i == 0) ? p0 : (i == 1) ? p1 : p2;
            @(posedge clk);
        end
        ptr_wr_en <= 1'b0;
    endtask

    // Presents a word so that the next edge is a Q1 edge; returns just after that edge.
    task automatic issue(input logic [15:0] w);
        @(posedge clk);
        while (q_phase !== Q_LAST) @(posedge clk);
        word_valid <= 1'b1;
        fetch_word <= w;
        @(posedge clk);
        word_valid <= 1'b0;
        fetch_word <= 16'h0000;
    endtask

    task automatic exec(input logic [15:0] w1, input logic [15:0] w2, input logic two);
        #1;
        n_wr  = 4'h0;
        n_pc  = 4'h0;
        n_clm = 4'h0;
        issue(w1);
        if (two) issue(w2);
        repeat (10) @(posedge clk);
        #1;
    endtask

    initial begin
        // No row names a program counter or return stack byte as destination.
        add_row(16'hFA08, 16'h0000, 1'b0, 12'h1EC, 4'h1, 12'h1EC, 8'h08, 4'h0, 4'h4,
                12'h100, 12'h200, 12'h1EB);
        add_row(16'hFAFF, 16'h0000, 1'b0, 12'h000, 4'h1, 12'h000, 8'hFF, 4'h0, 4'h4,
                12'h100, 12'h200, 12'hFFF);
        add_row(16'hE923, 16'h0000, 1'b0, 12'h3FF, 4'h0, 12'h000, 8'h00, 4'h0, 4'h4,
                12'h0DD, 12'h200, 12'h3FF);
        add_row(16'hE97F, 16'h0000, 1'b0, 12'h3FF, 4'h0, 12'h000, 8'h00, 4'h0, 4'h4,
                12'h100, 12'h1C1, 12'h3FF);
        add_row(16'hE9A3, 16'h0000, 1'b0, 12'h3FF, 4'h0, 12'h000, 8'h00, 4'h0, 4'h4,
                12'h100, 12'h200, 12'h3DC);
        add_row(16'hE9E3, 16'hFA55, 1'b1, 12'h3FF, 4'h0, 12'h000, 8'h00, 4'h1, 4'h8,
                12'h100, 12'h200, 12'h3DC);
        add_row(16'hEB05, 16'hF123, 1'b1, 12'h080, 4'h1, 12'h123, mfun(12'h085), 4'h0, 4'h8,
                12'h100, 12'h200, 12'h080);
        add_row(16'hEB7F, 16'hFFFF, 1'b1, 12'hF80, 4'h1, 12'hFFF, mfun(12'hFFF), 4'h0, 4'h8,
                12'h100, 12'h200, 12'hF80);
        add_row(16'hEB85, 16'hFF06, 1'b1, 12'h080, 4'h1, 12'h086, mfun(12'h085), 4'h0, 4'h8,
                12'h100, 12'h200, 12'h080);
        add_row(16'hEB0B, 16'hF050, 1'b1, 12'hFE0, 4'h1, 12'h050, 8'h00, 4'h0, 4'h8,
                12'h100, 12'h200, 12'hFE0);
        add_row(16'hEB80, 16'hF00B, 1'b1, 12'hFE0, 4'h0, 12'h000, 8'h00, 4'h0, 4'h8,
                12'h100, 12'h200, 12'hFE0);
        add_row(16'hEB05, 16'hE123, 1'b1, 12'h080, 4'h0, 12'h000, 8'h00, 4'h0, 4'h8,
                12'h100, 12'h200, 12'h080);
        repeat (16) @(posedge clk);
        #1;
        `CHECK(claimed, 1'b0)
        `CHECK(mem_wr.en, 1'b0)
        `CHECK(mem_rd.en, 1'b0)
        `CHECK(q_phase, Q_DECODE)
        `CHECK(fp[2], PTR_RESET)
        @(posedge clk);
        nrst <= 1'b1;
        $display("Test reset done");
        for (int i = 0; i < N_ROWS; i++) begin
            load_ptrs(12'h100, 12'h200, rows[i].frame);
            exec(rows[i].w1, rows[i].w2, rows[i].two);
            `CHECK(n_wr, rows[i].nwr)
            if (rows[i].nwr != 4'h0) `CHECK(wr_addr, rows[i].waddr)
            if (rows[i].nwr != 4'h0) `CHECK(wr_data, rows[i].wdata)
            `CHECK(n_pc, rows[i].npc)
            if (rows[i].npc != 4'h0) `CHECK(pc_seen, TOS_VALUE)
            `CHECK(n_clm, rows[i].clm)
            `CHECK(fp[0], rows[i].e0)
            `CHECK(fp[1], rows[i].e1)
            `CHECK(fp[2], rows[i].e2)
            $display("Test row %0d done", i);
        end
        // With the extension disabled a push must leave memory and pointers alone.
        extended_set_enable <= 1'b0;
        load_ptrs(12'h100, 12'h200, 12'h1EC);
        exec(16'hFA08, 16'h0000, 1'b0);
        `CHECK(n_wr, 4'h0)
        `CHECK(n_clm, 4'h0)
        `CHECK(fp[2], 12'h1EC)
        $display("Test disabled done");
        extended_set_enable <= 1'b1;
        // Reset in mid-instruction must abandon the pending write; the block works after it.
        load_ptrs(12'h100, 12'h200, 12'h1EC);
        n_wr = 4'h0;
        issue(16'hFA08);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        `CHECK(claimed, 1'b0)
        `CHECK(fp[2], PTR_RESET)
        repeat (4) @(posedge clk);
        `CHECK(n_wr, 4'h0)
        nrst <= 1'b1;
        exec(16'hFA08, 16'h0000, 1'b0);
        `CHECK(n_wr, 4'h1)
        `CHECK(wr_addr, PTR_RESET)
        `CHECK(wr_data, 8'h08)
        `CHECK(fp[2], 12'hFFF)
        $display("Test mid reset done");
        complete_run();
    end
endmodule

`default_nettype wire
